// *** bench/sssq_phase_model.sv ***
`timescale 1ns/10ps
// stands in for the phase stage: switching ticks, regulation and amp headroom
module sssq_phase_model (
	input  wire        clock,
	input  wire        rst_n,
	input  wire        error_amp_clamp,
	input  wire [15:0] softstart_level,
	output reg         switch_tick,
	output reg         in_regulation,
	output reg         amp_high_flag
);
	reg [2:0] div_q; // five-clock switching period
	reg [4:0] hi_q;  // clocks since amp release

	// the amp briefly saturates after release, shorter than the open-loop count
	always @(posedge clock) begin
		if (!rst_n) begin
			div_q <= 3'h0;
			hi_q <= 5'h0;
			switch_tick <= 1'b0;
			in_regulation <= 1'b0;
			amp_high_flag <= 1'b0;
		end else begin
			div_q <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
			switch_tick <= (div_q == 3'h4);
			in_regulation <= !error_amp_clamp && softstart_level >= 16'd1400;
			hi_q <= error_amp_clamp ? 5'h0 : ((hi_q == 5'h1F) ? hi_q : hi_q + 5'h1);
			amp_high_flag <= !error_amp_clamp && hi_q < 5'h0F;
		end
	end
endmodule // sssq_phase_model

// *** bench/sssq_seq_sva.sv ***
`timescale 1ns/10ps
// watches the sequencer pins; flags pass two sync stages, so bounds allow a few clocks
module sssq_seq_sva #(
	parameter SS_W = 16 // soft-start level width
) (
	input wire            clock,
	input wire            rst_n,
	input wire            enable_lo,
	input wire            ov_flag,
	input wire            hot_trip,
	input wire [SS_W-1:0] softstart_level,
	input wire            error_amp_clamp,
	input wire            boot_stage,
	input wire            code_active,
	input wire            regulator_ready_out,
	input wire            thermal_alarm_out_n,
	input wire            overvoltage_flag_pin,
	input wire            phase_share_line
);
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	// amp is released only once the node passes the clamp level
	clamp_release_a: assert property ($fell(error_amp_clamp) |-> softstart_level >= 16'd1400)
		else $error("amp released below clamp level");
	// boot stage hands over to the code only above the code threshold
	code_release_a: assert property ($rose(code_active) && $past(boot_stage) |-> softstart_level >= 16'd3000)
		else $error("code released early");
	ready_level_a: assert property ($rose(regulator_ready_out) |-> softstart_level >= 16'd3920)
		else $error("ready below threshold");
	level_cap_a: assert property (softstart_level <= 16'd4000)
		else $error("node above end level");
	// disable must knock ready down within the sync latency
	enable_drop_a: assert property ($rose(enable_lo) |-> ##[1:5] !regulator_ready_out)
		else $error("ready kept after disable");
	ov_alarm_a: assert property ($rose(ov_flag) |-> ##[1:4] (overvoltage_flag_pin && phase_share_line))
		else $error("overvoltage not signalled");
	ov_ready_a: assert property (overvoltage_flag_pin |=> !regulator_ready_out)
		else $error("ready with overvoltage latched");
	clamp_ready_a: assert property (error_amp_clamp [*2] |-> !regulator_ready_out)
		else $error("ready while amp clamped");
	hot_alarm_a: assert property ($rose(hot_trip) |-> ##[1:4] !thermal_alarm_out_n)
		else $error("thermal alarm missing");
endmodule // sssq_seq_sva

bind sssq_sequencer sssq_seq_sva #(.SS_W(SS_W)) sssq_seq_sva_inst (.clock, .rst_n, .enable_lo,
	.ov_flag, .hot_trip, .softstart_level, .error_amp_clamp, .boot_stage, .code_active,
	.regulator_ready_out, .thermal_alarm_out_n, .overvoltage_flag_pin, .phase_share_line);

// *** bench/tb.sv ***
`timescale 1ns/10ps
module tb;
	reg clock, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	reg [7:0] s_axi_awaddr, s_axi_araddr, voltage_ident_code;
	reg [31:0] s_axi_wdata, rnd;
	reg [3:0] s_axi_wstrb;
	reg enable_hi, enable_lo, bias_rail_ok_hi, oc_flag, ov_flag, hot_trip, hot_clear;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire switch_tick, in_regulation, amp_high_flag, softstart_charge, softstart_discharge;
	wire error_amp_clamp, boot_stage, code_active, const_current, regulator_ready_out;
	wire thermal_alarm_out_n, overvoltage_flag_pin, phase_share_line;
	wire [15:0] softstart_level;
	reg enable_hi_alt, enable_lo_alt;  // 5/6-bit family enable comparators
	reg bias_rail_low, open_chain_flag;
	wire open_sense_flag = 1'b0;       // shares the hard latch with the open chain
	int err_total, checked, n;
	reg [15:0] ocd;              // overcurrent delay in ticks

	sssq_sequencer sssq_sequencer_inst (.*);
	sssq_phase_model sssq_phase_model_inst (.*);

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task chk(input [39:0] g, input [39:0] e);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task cyc(input int c);
		repeat (c) @(posedge clock);
	endtask

	// one write; valids drop at the edge that takes them, bready held until bvalid
	task axw(input [7:0] a, input [31:0] d, input [1:0] er);
		int k;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= rnd[3:0];
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		k = 0;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			k++;
		end while (s_axi_bvalid !== 1'b1 && k < 100);
		s_axi_bready <= 1'b0;
		chk({s_axi_bvalid, s_axi_bresp}, {1'b1, er});
	endtask

	task axr(input [7:0] a, input [31:0] ed, input [1:0] er);
		int k;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		k = 0;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			k++;
		end while (s_axi_rvalid !== 1'b1 && k < 100);
		s_axi_rready <= 1'b0;
		chk({s_axi_rvalid, s_axi_rresp, s_axi_rdata}, {1'b1, er, ed});
	endtask

	// bounded wait for the ready pin to reach a level
	task wrdy(input v, input int lim);
		int k;
		k = 0;
		while (regulator_ready_out !== v && k < lim) begin
			@(posedge clock);
			k++;
		end
		chk(regulator_ready_out, v);
	endtask

	task end_of_test;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// watchdog: the scenarios need about 60000 clocks, so allow some margin
	initial begin
		repeat (80000) @(posedge clock);
		err_total++;
		end_of_test;
	end

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{enable_lo, enable_hi_alt, enable_lo_alt, bias_rail_low, open_chain_flag} = 5'h00;
		{bias_rail_ok_hi, oc_flag, ov_flag, hot_trip, hot_clear} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
		enable_hi = 1'b1;
		voltage_ident_code = 8'h40;
		rnd = 32'h75FE;
		rst_n = 1'b0;
		cyc(12);
		rst_n <= 1'b1;
		axr(8'h00, 32'h0, 2'b00);
		axr(8'h10, 32'h40, 2'b00);
		axr(8'h14, 32'h0, 2'b10);
		axw(8'h04, 32'h1, 2'b10);
		rnd = lfsr(rnd);
		ocd = {8'h00, rnd[7:0]} | 16'h0008;
		axw(8'h10, {16'h0, ocd}, 2'b00);
		axr(8'h10, {16'h0, ocd}, 2'b00);
		// rail not yet good: no start
		cyc(100);
		chk({regulator_ready_out, softstart_charge}, 2'b00);
		bias_rail_ok_hi <= 1'b1;
		voltage_ident_code <= {2'b01, rnd[13:8]};
		wrdy(1'b1, 6000);
		chk({code_active, softstart_level >= 16'd3920}, 2'b11);
		// disable, then restart
		enable_hi <= 1'b0;
		enable_lo <= 1'b1;
		wrdy(1'b0, 6);
		cyc(20);
		enable_lo <= 1'b0;
		enable_hi <= 1'b1;
		wrdy(1'b1, 20000);
		// no-boot mode; a code glitch shorter than the persistence window
		axw(8'h00, 32'h1, 2'b00);
		voltage_ident_code <= 8'h00;
		cyc(10);
		voltage_ident_code <= {2'b01, rnd[21:16]};
		cyc(40);
		chk(regulator_ready_out, 1'b1);
		voltage_ident_code <= 8'hFE;
		wrdy(1'b0, 40);
		voltage_ident_code <= {2'b01, rnd[29:24]};
		// overcurrent during the restart ramp
		for (n = 0; n < 20000 && softstart_level > 16'd1000; n++) @(posedge clock);
		for (n = 0; n < 20000 && softstart_level < 16'd1500; n++) @(posedge clock);
		oc_flag <= 1'b1;
		cyc(5);
		chk(const_current, 1'b1);
		cyc(5 * ocd + 60);
		chk(softstart_discharge, 1'b1);
		oc_flag <= 1'b0;
		wrdy(1'b1, 20000);
		// overcurrent after ready: discharge first, fault later
		oc_flag <= 1'b1;
		cyc(8);
		chk({regulator_ready_out, softstart_discharge}, 2'b11);
		wrdy(1'b0, 8000);
		// still over: the node bleeds to the fault level and hiccups near the floor
		cyc(4200);
		chk(softstart_level < 16'd200, 1'b1);
		oc_flag <= 1'b0;
		wrdy(1'b1, 20000);
		// thermal alarm holds until the clear comparator
		hot_trip <= 1'b1;
		cyc(5);
		chk(thermal_alarm_out_n, 1'b0);
		hot_trip <= 1'b0;
		cyc(5);
		chk(thermal_alarm_out_n, 1'b0);
		hot_clear <= 1'b1;
		cyc(5);
		chk(thermal_alarm_out_n, 1'b1);
		// overvoltage latches for good
		ov_flag <= 1'b1;
		cyc(5);
		chk({overvoltage_flag_pin, phase_share_line, regulator_ready_out}, 3'b110);
		ov_flag <= 1'b0;
		cyc(20);
		chk(regulator_ready_out, 1'b0);
		// power cycle clears the hard and overvoltage latches (reset sets the fault latch); rerun in the 5-bit family
		rst_n <= 1'b0;
		enable_hi_alt <= 1'b1;
		voltage_ident_code <= {3'h1, rnd[4:1], 1'b0};
		cyc(3);
		chk({overvoltage_flag_pin, phase_share_line, regulator_ready_out}, 3'b000);
		rst_n <= 1'b1;
		axw(8'h00, 32'h2, 2'b00);
		wrdy(1'b1, 6000);
		enable_hi_alt <= 1'b0;
		enable_lo_alt <= 1'b1;
		wrdy(1'b0, 6);
		enable_lo_alt <= 1'b0;
		enable_hi_alt <= 1'b1;
		wrdy(1'b1, 20000);
		voltage_ident_code <= 8'h3F;
		wrdy(1'b0, 40);
		voltage_ident_code <= {3'h1, rnd[8:5], 1'b0};
		// rail sags during the discharge: no restart until it recovers
		bias_rail_low <= 1'b1;
		cyc(4500);
		chk({regulator_ready_out, softstart_charge}, 2'b00);
		bias_rail_low <= 1'b0;
		wrdy(1'b1, 6000);
		// open chain latches for good, even once the flag goes away
		open_chain_flag <= 1'b1;
		wrdy(1'b0, 6);
		open_chain_flag <= 1'b0;
		cyc(4500);
		chk({regulator_ready_out, softstart_charge}, 2'b00);
		end_of_test;
	end
endmodule // tb

// *** src/sssq_defs.vh ***
`ifndef SSSQ_DEFS_VH
`define SSSQ_DEFS_VH

// register byte offsets (one aligned word each)
`define SSSQ_OFF_CTRL      8'h00
`define SSSQ_OFF_STATUS    8'h04
`define SSSQ_OFF_FAULTS    8'h08
`define SSSQ_OFF_SSLEVEL   8'h0C
`define SSSQ_OFF_OCDELAY   8'h10

// control register fields
`define SSSQ_CTRL_TABLE_LSB 0
`define SSSQ_CTRL_TABLE_W   2
`define SSSQ_CTRL_RESET     2'h0

// code table select encodings
`define SSSQ_TBL_BOOT8      2'h0
`define SSSQ_TBL_NOBOOT8    2'h1
`define SSSQ_TBL_5BIT       2'h2
`define SSSQ_TBL_6BIT       2'h3

// soft-start node thresholds in millivolts
`define SSSQ_SS_CLAMP_MV    16'd1400
`define SSSQ_SS_BOOT_MV     16'd1100
`define SSSQ_SS_CODE_MV     16'd3000
`define SSSQ_SS_RDY_MV      16'd3920
`define SSSQ_SS_END_MV      16'd4000
`define SSSQ_SS_DIS_MV      16'd200
`define SSSQ_SS_OC_MV       16'd120

// timing: invalid-code persistence 1.3us, open loop 8 switching cycles
`define SSSQ_CLK_MHZ        20
`define SSSQ_VIDF_NS        1300
`define SSSQ_VIDF_CYC       ((`SSSQ_VIDF_NS * `SSSQ_CLK_MHZ) / 1000)
`define SSSQ_OPENLOOP_CYC   4'd8
`define SSSQ_OCDELAY_RESET  16'h0040

`endif

// *** src/sssq_sequencer.v ***
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "sssq_defs.vh"

// Function
// (R1) boot mode: charge soft start once enabled
// (R2) clamp amp until 1.4V, then track minus offset
// (R3) boot mode: release code above 3.0V
// (R4) ready allowed above 3.92V; ends at 4.0V
// (R5) no-boot modes track straight to code
// (R6) undervoltage, bad code, overcurrent, disable set fault
// (R7) discharge trip with cause gone restarts
// (R8) overvoltage, open sense/loop/chain latch until power cycle
// (R9) overcurrent before ready: constant current, count delay
// (R10) overcurrent past delay: fault, discharge, hiccup
// (R11) delay count chosen from switching frequency
// (R12) post-ready overcurrent discharges; below 120mV faults
// (R13) post-ready fault discharges to 200mV, retries
// (R14) bias rail above 94% releases, below 86% sets; the code needs 94% only at first start, then release follows the 86% flag
// (R15) all-zero/all-one codes set fault; 5-bit table flags only all-one, 6-bit table never flags a code
// (R16) invalid code must persist 1.3us
// (R17) boot mode code fault held until power cycle
// (R18) ready high only when done, low on latches
// (R19) amp high 8 switching cycles latches fault
// (R20) 8-bit family enable thresholds 0.8/0.85V
// (R21) 5/6-bit family enable thresholds 1.14/1.2V
// (R22) thermal alarm pulled low at trip, hysteresis
// (R23) overvoltage raises flag, latch, share line
// (R24) all flags pass two-stage synchronisers
module sssq_sequencer #(
	parameter SS_W = 16 // soft-start level width, millivolts
) (
	input  wire        clock,
	input  wire        rst_n,
	// axi4-lite slave
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// analog flags and pins
	input  wire        enable_hi,        // enable above the on threshold
	input  wire        enable_lo,        // enable below the off threshold
	input  wire        enable_hi_alt,    // enable above 1.2V
	input  wire        enable_lo_alt,    // enable below 1.14V
	input  wire        bias_rail_ok_hi,  // rail above 94%
	input  wire        bias_rail_low,    // rail below 86%
	input  wire        oc_flag,          // current_sense_in above overcurrent_threshold
	input  wire        ov_flag,          // sensed_output above dac_reference + 130mV
	input  wire        open_sense_flag,  // open sense line detected
	input  wire        open_chain_flag,  // open daisy chain detected
	input  wire        amp_high_flag,    // error amp above rail minus 1.08V
	input  wire        hot_trip,         // thermal_threshold_in past 1.6V
	input  wire        hot_clear,        // thermal back below hysteresis band
	input  wire        in_regulation,    // output within regulation
	input  wire        switch_tick,      // one pulse per switching cycle
	input  wire [7:0]  voltage_ident_code,
	output reg         softstart_charge,
	output reg         softstart_discharge,
	output reg  [SS_W-1:0] softstart_level,
	output reg         error_amp_clamp,
	output reg         boot_stage,
	output reg         code_active,
	output reg         const_current,
	output reg         regulator_ready_out,
	output reg         thermal_alarm_out_n,
	output reg         overvoltage_flag_pin,
	output reg         phase_share_line
);

	localparam [SS_W-1:0] SS_STEP = 16'd1; // ramp step per clock, mV

	// synchronised flags: first stage feeds only the second
	localparam NF = 14;
	wire [NF-1:0] raw_w = {in_regulation, hot_clear, hot_trip, amp_high_flag,
		open_chain_flag, open_sense_flag, ov_flag, oc_flag, bias_rail_low,
		bias_rail_ok_hi, enable_lo_alt, enable_hi_alt, enable_lo, enable_hi};
	reg  [NF-1:0] sy1_q;  // first stage
	reg  [NF-1:0] sy2_q;  // second stage, used by logic
	reg  [7:0]    code1_q;
	reg  [7:0]    code2_q;

	// code bus synced bitwise: skew lasts a clock, far inside the persistence window
	// sync every flag through two stages
	always @(posedge clock) begin
		if (!rst_n) begin
			sy1_q   <= {NF{1'b0}};
			sy2_q   <= {NF{1'b0}};
			code1_q <= 8'h00;
			code2_q <= 8'h00;
		end else begin
			sy1_q   <= raw_w; // see (R24)
			sy2_q   <= sy1_q;
			code1_q <= voltage_ident_code;
			code2_q <= code1_q;
		end
	end

	wire en_hi_s = sy2_q[0];
	wire en_lo_s = sy2_q[1];
	wire ea_hi_s = sy2_q[2];
	wire ea_lo_s = sy2_q[3];
	wire rail_ok_s  = sy2_q[4];
	wire rail_low_s = sy2_q[5];
	wire oc_s   = sy2_q[6];
	wire ov_s   = sy2_q[7];
	wire osen_s = sy2_q[8];
	wire ochn_s = sy2_q[9];
	wire amph_s = sy2_q[10];
	wire hot_s  = sy2_q[11];
	wire cool_s = sy2_q[12];
	wire reg_s  = sy2_q[13];

	// the table select strap is not modelled; software sets the family instead
	// software state
	reg  [1:0]  table_q;    // code_table_select
	reg  [15:0] ocdelay_q;  // overcurrent delay in switching cycles
	reg         por_q;      // cleared once rail first seen good

	wire is_8bit = (table_q == `SSSQ_TBL_BOOT8) || (table_q == `SSSQ_TBL_NOBOOT8);
	wire is_boot = (table_q == `SSSQ_TBL_BOOT8);

	// enable thresholds depend on code family
	wire en_on  = is_8bit ? en_hi_s : ea_hi_s; // see (R20) (R21)
	wire en_off = is_8bit ? en_lo_s : ea_lo_s; // see (R20) (R21)

	// invalid code detect per table
	reg bad_code;
	always @* begin
		case (table_q)
			`SSSQ_TBL_5BIT: bad_code = (code2_q[4:0] == 5'h1F); // see (R15)
			`SSSQ_TBL_6BIT: bad_code = 1'b0;
			default: bad_code = (code2_q[7:1] == 7'h00) || (code2_q[7:1] == 7'h7F); // see (R15)
		endcase
	end

	// invalid code must persist before it counts
	// the macro is a plain integer; keep only the counter's width
	localparam [31:0] VIDF_WIDE = `SSSQ_VIDF_CYC;
	localparam [7:0]  VIDF_CYC  = VIDF_WIDE[7:0];
	reg [7:0] vidf_cnt_q;
	reg       vidf_q;
	always @(posedge clock) begin
		if (!rst_n) begin
			vidf_cnt_q <= 8'h00;
			vidf_q     <= 1'b0;
		end else if (!bad_code) begin
			vidf_cnt_q <= 8'h00;
			vidf_q     <= 1'b0;
		end else if (vidf_cnt_q >= VIDF_CYC - 8'h01) begin
			vidf_q <= 1'b1; // see (R16)
		end else begin
			vidf_cnt_q <= vidf_cnt_q + 8'h01;
		end
	end

	// open loop: amp high for 8 consecutive switching cycles
	// the count saturates at the limit so the latch input stays asserted
	reg [3:0] ol_cnt_q;
	always @(posedge clock) begin
		if (!rst_n)
			ol_cnt_q <= 4'h0;
		else if (!amph_s)
			ol_cnt_q <= 4'h0;
		else if (switch_tick && ol_cnt_q != `SSSQ_OPENLOOP_CYC)
			ol_cnt_q <= ol_cnt_q + 4'h1; // see (R19)
	end

	// state machine
	localparam [2:0] ST_OFF   = 3'd0; // fault or waiting
	localparam [2:0] ST_RAMP  = 3'd1; // soft start rising
	localparam [2:0] ST_DONE  = 3'd2; // settled at end level
	localparam [2:0] ST_DISCH = 3'd3; // fault discharge
	reg [2:0]  st_q;
	reg [15:0] ocd_cnt_q;  // constant-current delay count
	reg        fault_q;    // recoverable fault latch
	reg        hard_q;     // power-cycle-only latches
	reg        ovl_q;      // overvoltage latch

	wire rail_fault = rail_low_s || por_q;        // see (R14)
	wire hard_set = ov_s || osen_s || ochn_s       // see (R8)
		|| (ol_cnt_q == `SSSQ_OPENLOOP_CYC)         // see (R19)
		|| (vidf_q && is_boot);                     // see (R17)
	wire soft_set = rail_fault || vidf_q || en_off || !en_on; // see (R6)
	wire cause = soft_set || hard_set || hard_q;

	// sequencing and fault latches
	always @(posedge clock) begin
		if (!rst_n) begin
			st_q      <= ST_OFF;
			softstart_level <= {SS_W{1'b0}};
			ocd_cnt_q <= 16'h0000;
			fault_q   <= 1'b1;
			hard_q    <= 1'b0;
			ovl_q     <= 1'b0;
			por_q     <= 1'b1;
		end else begin
			if (rail_ok_s)
				por_q <= 1'b0; // see (R14)
			if (hard_set)
				hard_q <= 1'b1; // see (R8)
			if (ov_s)
				ovl_q <= 1'b1; // see (R23)
			case (st_q)
				ST_OFF: begin
					// restart only when no cause and node discharged
					if (!cause) begin
						fault_q <= 1'b0;      // see (R7) (R13)
						st_q    <= ST_RAMP;   // see (R1)
					end
				end
				ST_RAMP: begin
					if (cause || (oc_s && ocd_cnt_q >= ocdelay_q)) begin
						fault_q <= 1'b1;      // see (R6) (R10)
						st_q    <= ST_DISCH;
					end else if (oc_s) begin
						// hold level: constant-current control
						if (switch_tick)
							ocd_cnt_q <= ocd_cnt_q + 16'h0001; // see (R9) (R11)
					end else begin
						ocd_cnt_q <= 16'h0000;
						if (softstart_level >= `SSSQ_SS_END_MV)
							st_q <= ST_DONE; // see (R4)
						else
							softstart_level <= softstart_level + SS_STEP;
					end
				end
				ST_DONE: begin
					if (cause) begin
						fault_q <= 1'b1;
						st_q    <= ST_DISCH;
					end else if (oc_s) begin
						// excess current pulls the node down
						if (softstart_level < `SSSQ_SS_OC_MV) begin
							fault_q <= 1'b1;  // see (R12)
							st_q    <= ST_DISCH;
						end else
							softstart_level <= softstart_level - SS_STEP; // see (R12)
					end else if (softstart_level < `SSSQ_SS_END_MV)
						softstart_level <= softstart_level + SS_STEP;
				end
				ST_DISCH: begin
					if (softstart_level > `SSSQ_SS_DIS_MV)
						softstart_level <= softstart_level - SS_STEP; // see (R10) (R13)
					else
						st_q <= ST_OFF; // see (R7)
				end
				default: st_q <= ST_OFF;
			endcase
		end
	end

	// pin outputs derived from state
	always @(posedge clock) begin
		if (!rst_n) begin
			softstart_charge     <= 1'b0;
			softstart_discharge  <= 1'b0;
			error_amp_clamp      <= 1'b1;
			boot_stage           <= 1'b0;
			code_active          <= 1'b0;
			const_current        <= 1'b0;
			regulator_ready_out  <= 1'b0;
			thermal_alarm_out_n  <= 1'b1;
			overvoltage_flag_pin <= 1'b0;
			phase_share_line     <= 1'b0;
		end else begin
			softstart_charge    <= (st_q == ST_RAMP) && !oc_s; // see (R1)
			// post-ready overcurrent bleeds the node while still in the done state
			softstart_discharge <= (st_q == ST_DISCH)
				|| ((st_q == ST_DONE) && oc_s); // see (R12)
			error_amp_clamp <= fault_q || hard_q || ovl_q || (st_q != ST_RAMP && st_q != ST_DONE)
				|| softstart_level < `SSSQ_SS_CLAMP_MV; // see (R2) (R6) (R8)
			// boot stage holds output at 1.1V until code release
			boot_stage  <= is_boot && softstart_level >= `SSSQ_SS_CLAMP_MV
				&& softstart_level < `SSSQ_SS_CODE_MV; // see (R2)
			code_active <= is_boot ? (softstart_level > `SSSQ_SS_CODE_MV) : 1'b1; // see (R3) (R5)
			const_current <= (st_q == ST_RAMP) && oc_s; // see (R9)
			regulator_ready_out <= (st_q == ST_DONE) && reg_s && !fault_q && !hard_q
				&& !ovl_q && softstart_level > `SSSQ_SS_RDY_MV; // see (R4) (R18)
			// trip wins over clear when both comparators report at once
			if (hot_s)
				thermal_alarm_out_n <= 1'b0; // see (R22)
			else if (cool_s)
				thermal_alarm_out_n <= 1'b1;
			overvoltage_flag_pin <= ovl_q || ov_s; // see (R23)
			phase_share_line     <= ovl_q || ov_s; // see (R23)
		end
	end

	// axi4-lite write: take address and data in either order
	reg        aw_have_q;
	reg        w_have_q;
	reg [7:0]  awaddr_q;
	reg [31:0] wdata_q;
	always @(posedge clock) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			table_q   <= `SSSQ_CTRL_RESET;
			ocdelay_q <= `SSSQ_OCDELAY_RESET;
		end else begin
			s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
			s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
			end
			if (aw_have_q && w_have_q && !s_axi_bvalid) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'b00;
				case (awaddr_q)
					`SSSQ_OFF_CTRL:    table_q   <= wdata_q[1:0];
					`SSSQ_OFF_OCDELAY: ocdelay_q <= wdata_q[15:0]; // see (R11)
					default: s_axi_bresp <= 2'b10; // unmapped or read-only
				endcase
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// axi4-lite read
	// status words are snapshots; a read never disturbs the latches
	always @(posedge clock) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'b00;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= 2'b00;
				case (s_axi_araddr)
					`SSSQ_OFF_CTRL:    s_axi_rdata <= {30'h0, table_q};
					`SSSQ_OFF_STATUS:  s_axi_rdata <= {25'h0, st_q, regulator_ready_out,
						code_active, const_current, error_amp_clamp};
					`SSSQ_OFF_FAULTS:  s_axi_rdata <= {28'h0, ovl_q, hard_q, vidf_q, fault_q};
					`SSSQ_OFF_SSLEVEL: s_axi_rdata <= {16'h0, softstart_level};
					`SSSQ_OFF_OCDELAY: s_axi_rdata <= {16'h0, ocdelay_q};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= 2'b10;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule // sssq_sequencer
